// ### bench/dopw_load.sv
// load model on the two modulator pins, with the port pull-ups
`timescale 1ns/1ns
module dopw_load (
  input wire logic pin_a_i,
  input wire logic pin_b_i,
  input wire logic oe_a_i,
  input wire logic oe_b_i,
  output logic pad_a_o,
  output logic pad_b_o
);
  // ****************************************
  // pad levels
  // ****************************************
  // a released pin floats up to the port pull-up, never to the last driven level
  assign pad_a_o = oe_a_i ? pin_a_i : 1'b1;
  assign pad_b_o = oe_b_i ? pin_b_i : 1'b1;
endmodule : dopw_load

// ### bench/test_dual_output_pwm_unit.sv
// self-checking bench of the dual-output modulator
`timescale 1ns/1ns
`include "dopw_defs.svh"
module test_dual_output_pwm_unit;
  typedef struct {
    logic [7:0] ctrl;
    logic [15:0] a;
    logic [15:0] b;
    logic [31:0] win;
    logic [31:0] ea;
    logic [31:0] eb;
  } dopw_row_type;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic xtal_tick_i = 1'b0;
  logic vco_tick_i = 1'b1;
  logic ext_pin = 1'b0;
  logic [1:0] ext_div = 2'h0;
  logic [7:0] sfr_rdata_o;
  logic pin_a, pin_b, oe_a, oe_b, pad_a, pad_b;
  logic [31:0] cnt_a, cnt_b;
  int miscompares = 0;
  int check_count = 0;
  int wait_n;
  dopw_row_type rows [15];

  // ****************************************
  // clock, sources and instances
  // ****************************************
  always #20 ref_clk_i = ~ref_clk_i;

  // crystal enable every second cycle, external pin rising every fourth
  always @(negedge ref_clk_i)
  begin
    xtal_tick_i <= ~xtal_tick_i;
    ext_div <= ext_div + 2'h1;
    ext_pin <= ext_div[1];
  end

  dopw_core #(.CNT_W(16)) uut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o),
    .xtal_tick_i(xtal_tick_i),
    .vco_tick_i(vco_tick_i),
    .external_clock_pin_i(ext_pin),
    .first_output_pin_o(pin_a),
    .second_output_pin_o(pin_b),
    .first_output_pin_oe_o(oe_a),
    .second_output_pin_oe_o(oe_b)
  );

  dopw_load load (
    .pin_a_i(pin_a),
    .pin_b_i(pin_b),
    .oe_a_i(oe_a),
    .oe_b_i(oe_b),
    .pad_a_o(pad_a),
    .pad_b_o(pad_b)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk_i);
    sfr_addr_i = addr;
    sfr_wdata_i = data;
    sfr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_write

  // read data lands one cycle after the read edge
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge ref_clk_i);
    sfr_addr_i = addr;
    sfr_rd_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
    @(negedge ref_clk_i);
    check({24'h0000_00, sfr_rdata_o}, {24'h0000_00, exp});
  endtask : rd_chk

  // words go in while disabled, low byte first, so the mode starts on them
  task automatic setup(input logic [15:0] a, input logic [15:0] b, input logic [7:0] ctrl);
    sfr_write(`DOPW_ADDR_CTRL, 8'h00);
    sfr_write(`DOPW_ADDR_A_LO, a[7:0]);
    sfr_write(`DOPW_ADDR_A_HI, a[15:8]);
    sfr_write(`DOPW_ADDR_B_LO, b[7:0]);
    sfr_write(`DOPW_ADDR_B_HI, b[15:8]);
    sfr_write(`DOPW_ADDR_CTRL, ctrl);
    repeat (8) @(negedge ref_clk_i);
  endtask : setup

  task automatic measure(input logic [31:0] win);
    cnt_a = 32'h0000_0000;
    cnt_b = 32'h0000_0000;
    repeat (win) @(negedge ref_clk_i)
    begin
      cnt_a = cnt_a + {31'h0, pad_a};
      cnt_b = cnt_b + {31'h0, pad_b};
    end
  endtask : measure

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // watchdog
  // ****************************************
  // about 72k cycles of tests; the 16-bit row dominates; limit at 90k cycles
  initial
  begin
    #3_600_000;
    miscompares++;
    report_and_stop();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rows = '{
      '{8'h03, 16'h0000, 16'h0000, 64, 64, 64},
      '{8'h73, 16'h0000, 16'h0000, 64, 64, 64},
      '{8'h13, 16'h0064, 16'h00c7, 400, 200, 0},
      '{8'h17, 16'h0005, 16'h0009, 400, 200, 0},
      '{8'h1b, 16'h0005, 16'h0009, 640, 320, 0},
      '{8'h1f, 16'h0005, 16'h0009, 640, 320, 0},
      '{8'h11, 16'h0005, 16'h0009, 400, 200, 0},
      '{8'h10, 16'h0005, 16'h0009, 600, 300, 0},
      '{8'h12, 16'h0005, 16'h0009, 400, 200, 0},
      '{8'h23, 16'h9040, 16'h10ff, 512, 128, 256},
      '{8'h23, 16'h3020, 16'h00ff, 512, 64, 96},
      '{8'h53, 16'h0510, 16'h0920, 330, 160, 165},
      '{8'h43, 16'h4000, 16'h8000, 256, 64, 128},
      '{8'h67, 16'h4000, 16'h8000, 256, 32, 64},
      '{8'h33, 16'h1000, 16'h8000, 65536, 4096, 32768}
    };
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    foreach (rows[i])
    begin
      setup(rows[i].a, rows[i].b, rows[i].ctrl);
      wait_n = (rows[i].ctrl[6:4] == 3'h0 || rows[i].ctrl[6:4] == 3'h7) ? 0 : 3;
      check({30'h0, oe_a, oe_b}, wait_n[31:0]);
      measure(rows[i].win);
      check(cnt_a, rows[i].ea);
      check(cnt_b, rows[i].eb);
      $display("row %0d done", i);
    end

    // second reset in mid-run, then register access
    @(negedge ref_clk_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    rd_chk(`DOPW_ADDR_CTRL, `DOPW_CTRL_RESET);
    check({30'h0, oe_a, oe_b}, 32'h0000_0000);
    sfr_write(`DOPW_ADDR_CTRL, 8'hff);
    rd_chk(`DOPW_ADDR_CTRL, 8'h7f);
    @(negedge ref_clk_i);
    check({30'h0, oe_a, oe_b}, 32'h0000_0000);
    rd_chk(8'h80, 8'h00);
    $display("reset and register test done");

    // staged low byte stays hidden until the high byte commits it
    setup(16'h0005, 16'h0009, 8'h13);
    sfr_write(`DOPW_ADDR_A_LO, 8'h08);
    rd_chk(`DOPW_ADDR_A_LO, 8'h05);
    measure(20);
    check(cnt_a, 32'h0000_000a);
    sfr_write(`DOPW_ADDR_A_HI, 8'h00);
    rd_chk(`DOPW_ADDR_A_LO, 8'h08);
    repeat (12) @(negedge ref_clk_i);
    measure(20);
    check(cnt_a, 32'h0000_0010);
    $display("staging test done");

    // control write in the low phase must restart the high phase
    setup(16'h0005, 16'h0013, 8'h13);
    wait_n = 0;
    while (pad_a !== 1'b0 && wait_n < 50)
    begin
      @(negedge ref_clk_i);
      wait_n++;
    end
    check({31'h0, pad_a}, 32'h0000_0000);
    @(negedge ref_clk_i);
    sfr_write(`DOPW_ADDR_CTRL, 8'h13);
    repeat (3) @(negedge ref_clk_i);
    check({31'h0, pad_a}, 32'h0000_0001);
    $display("counter clear test done");
    report_and_stop();
  end
endmodule : test_dual_output_pwm_unit

// ### rtl/dopw_clkgen.sv
// modulator clock source selection and prescaler, producing one-cycle ticks
`timescale 1ns/1ns
`include "dopw_defs.svh"
module dopw_clkgen (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic xtal_tick_i,
  input wire logic vco_tick_i,
  input wire logic external_clock_pin_i,
  dopw_tick_if.gen tk
);
  logic [3:0] div15;
  logic ext_q;
  logic [5:0] pcnt;
  logic tick;
  wire logic div_tick;
  wire logic ext_rise;
  wire logic src_tick;
  wire logic [5:0] lim;
  wire logic at_lim;

  // ************************************************
  // source select
  // ************************************************
  assign div_tick = xtal_tick_i && (div15 == `DOPW_XTAL_DIV_LAST);
  assign ext_rise = external_clock_pin_i && !ext_q;
  assign src_tick = (tk.src == `DOPW_SRC_XTAL_DIV) ? div_tick :
                    (tk.src == `DOPW_SRC_XTAL) ? xtal_tick_i :
                    (tk.src == `DOPW_SRC_EXT) ? ext_rise : vco_tick_i;
  assign lim = (tk.presc == 2'h0) ? `DOPW_PRESC_LIM_1 :
               (tk.presc == 2'h1) ? `DOPW_PRESC_LIM_4 :
               (tk.presc == 2'h2) ? `DOPW_PRESC_LIM_16 : `DOPW_PRESC_LIM_64;
  assign at_lim = (pcnt >= lim);
  assign tk.tick = tick;

  // ************************************************
  // counters
  // ************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      div15 <= 4'h0;
      ext_q <= 1'b0;
    end
    else
    begin
      ext_q <= external_clock_pin_i;
      if (xtal_tick_i)
        div15 <= div_tick ? 4'h0 : div15 + 4'h1;
    end
  end

  // control write restarts the prescaler so the first tick is a full division
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pcnt <= 6'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= src_tick && at_lim && !tk.clr;
      if (tk.clr)
        pcnt <= 6'h00;
      else if (src_tick)
        pcnt <= at_lim ? 6'h00 : pcnt + 6'h01;
    end
  end

  chk_undivided_tick: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (tk.presc == 2'h0 && src_tick && !tk.clr) |=> tick)
    else $error("undivided source tick not passed on");
  chk_tick_needs_src: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    tick |-> $past(src_tick))
    else $error("tick without a source tick");
endmodule : dopw_clkgen

// ### rtl/dopw_core.sv
// dual-output pulse-width and sigma-delta modulator with its special function registers
// Notes on behaviour
// - control write clears the modulation counter
// - 16-bit modes: low byte staged, not applied
// - high write commits pair; applies at the next cycle end
// - control bits 6:4 select mode
// - control bits 3:2 prescale by 1/4/16/64
// - control bits 1:0 select modulator clock source
// - disabled mode releases both output pins
// - single mode: second pair sets period
// - single mode: first pair sets duty
// - twin 8-bit: second low byte sets period
// - twin 8-bit: first output low at first low
// - twin 8-bit: second output set/cleared by high bytes
// - twin 8-bit: zero high byte aligns rising edges
// - twin 16-bit: period fixed at full range
// - twin 16-bit: first output high below first word
// - twin 16-bit: second output high below second word
// - twin 16-bit: both outputs rise at rollover
// - NRZ sigma-delta: high exactly word clocks per 65536
// - dual 8-bit: separate periods, duties, common clock
// - RZ sigma-delta: each high clock half high
`timescale 1ns/1ns
`include "dopw_defs.svh"
module dopw_core #(
  parameter int CNT_W = `DOPW_CNT_W
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic xtal_tick_i,
  input wire logic vco_tick_i,
  input wire logic external_clock_pin_i,
  output logic first_output_pin_o,
  output logic second_output_pin_o,
  output logic first_output_pin_oe_o,
  output logic second_output_pin_oe_o
);
  if (CNT_W != 16)
  begin : g_bad_width
    $error("counter width must be 16");
  end

  dopw_pkg::dopw_mode_type mode;
  logic [1:0] presc;
  logic [1:0] src;
  logic [7:0] stage_a_lo;
  logic [7:0] stage_b_lo;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic [15:0] act_a;
  logic [15:0] act_b;
  logic pend;
  logic [15:0] cnt;
  logic [7:0] cnt_b;
  logic [15:0] acc_a;
  logic [15:0] acc_b;
  logic sd_a;
  logic sd_b;
  logic [15:0] since;
  logic [15:0] span;
  logic next_a;
  logic next_b;

  dopw_tick_if tk ();

  dopw_clkgen u_clkgen (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .xtal_tick_i(xtal_tick_i),
    .vco_tick_i(vco_tick_i),
    .external_clock_pin_i(external_clock_pin_i),
    .tk(tk.gen)
  );

  // ************************************************
  // decoding
  // ************************************************
  function automatic logic is_wide(input dopw_pkg::dopw_mode_type m);
    is_wide = (m == dopw_pkg::DOPW_SINGLE) || (m == dopw_pkg::DOPW_TWIN16) ||
              (m == dopw_pkg::DOPW_SD_NRZ) || (m == dopw_pkg::DOPW_SD_RZ);
  endfunction : is_wide

  function automatic logic [15:0] period_of(input dopw_pkg::dopw_mode_type m,
                                            input logic [15:0] w);
    case (m)
      dopw_pkg::DOPW_SINGLE: period_of = w;
      dopw_pkg::DOPW_TWIN8: period_of = {8'h00, w[7:0]};
      dopw_pkg::DOPW_DUAL8: period_of = {8'h00, w[7:0]};
      default: period_of = `DOPW_FULL_PERIOD;
    endcase
  endfunction : period_of

  wire logic wr_ctrl = sfr_wr_i && (sfr_addr_i == `DOPW_ADDR_CTRL);
  wire logic wr_a_lo = sfr_wr_i && (sfr_addr_i == `DOPW_ADDR_A_LO);
  wire logic wr_a_hi = sfr_wr_i && (sfr_addr_i == `DOPW_ADDR_A_HI);
  wire logic wr_b_lo = sfr_wr_i && (sfr_addr_i == `DOPW_ADDR_B_LO);
  wire logic wr_b_hi = sfr_wr_i && (sfr_addr_i == `DOPW_ADDR_B_HI);
  wire logic wide = is_wide(mode);
  wire logic off = (mode == dopw_pkg::DOPW_OFF) || (mode == dopw_pkg::DOPW_RSVD);
  wire logic tick = tk.tick;
  wire logic [15:0] period = period_of(mode, act_b);
  wire logic wrap_a = (cnt == period);
  wire logic wrap_b = (cnt_b == act_b[15:8]);
  wire logic cyc_end = tick && wrap_a && !wr_ctrl;
  wire logic load_act = off || (cyc_end && pend);
  wire logic [16:0] sum_a = {1'b0, acc_a} + {1'b0, act_a};
  wire logic [16:0] sum_b = {1'b0, acc_b} + {1'b0, act_b};
  wire logic rz_high = ({since, 1'b0} < {1'b0, span});
  wire logic [7:0] ctrl_rd = {1'b0, mode, presc, src};
  wire logic [7:0] rd_mux =
    (sfr_addr_i == `DOPW_ADDR_CTRL) ? ctrl_rd :
    (sfr_addr_i == `DOPW_ADDR_A_LO) ? word_a[7:0] :
    (sfr_addr_i == `DOPW_ADDR_A_HI) ? word_a[15:8] :
    (sfr_addr_i == `DOPW_ADDR_B_LO) ? word_b[7:0] :
    (sfr_addr_i == `DOPW_ADDR_B_HI) ? word_b[15:8] : 8'h00;

  assign tk.src = src;
  assign tk.presc = presc;
  assign tk.clr = wr_ctrl;
  assign first_output_pin_oe_o = !off;
  assign second_output_pin_oe_o = !off;

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode <= dopw_pkg::DOPW_OFF;
      presc <= 2'h0;
      src <= 2'h0;
      sfr_rdata_o <= `DOPW_CTRL_RESET;
    end
    else
    begin
      if (sfr_rd_i)
        sfr_rdata_o <= rd_mux;
      if (wr_ctrl)
      begin
        mode <= dopw_pkg::dopw_mode_type'(sfr_wdata_i[`DOPW_MODE_MSB:`DOPW_MODE_LSB]);
        presc <= sfr_wdata_i[`DOPW_PRESC_MSB:`DOPW_PRESC_LSB];
        src <= sfr_wdata_i[`DOPW_SRC_MSB:`DOPW_SRC_LSB];
      end
    end
  end

  // data words; a write landing on a cycle end keeps pend set for the next end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stage_a_lo <= 8'h00;
      stage_b_lo <= 8'h00;
      word_a <= `DOPW_ZERO_WORD;
      word_b <= `DOPW_ZERO_WORD;
      act_a <= `DOPW_ZERO_WORD;
      act_b <= `DOPW_ZERO_WORD;
      pend <= 1'b0;
    end
    else
    begin
      if (load_act)
      begin
        act_a <= word_a;
        act_b <= word_b;
        pend <= 1'b0;
      end
      if (wr_a_lo)
        stage_a_lo <= sfr_wdata_i;
      if (wr_b_lo)
        stage_b_lo <= sfr_wdata_i;
      if ((wr_a_lo || wr_b_lo) && !wide)
        pend <= 1'b1;
      if (wr_a_lo && !wide)
        word_a[7:0] <= sfr_wdata_i;
      if (wr_b_lo && !wide)
        word_b[7:0] <= sfr_wdata_i;
      if (wr_a_hi)
        word_a <= {sfr_wdata_i, wide ? stage_a_lo : word_a[7:0]};
      if (wr_b_hi)
        word_b <= {sfr_wdata_i, wide ? stage_b_lo : word_b[7:0]};
      if (wr_a_hi || wr_b_hi)
        pend <= 1'b1;
    end
  end

  // ************************************************
  // counters and accumulators
  // ************************************************
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt <= `DOPW_ZERO_WORD;
      cnt_b <= 8'h00;
      acc_a <= `DOPW_ZERO_WORD;
      acc_b <= `DOPW_ZERO_WORD;
      sd_a <= 1'b0;
      sd_b <= 1'b0;
    end
    else if (wr_ctrl || off)
    begin
      cnt <= `DOPW_ZERO_WORD;
      cnt_b <= 8'h00;
      acc_a <= `DOPW_ZERO_WORD;
      acc_b <= `DOPW_ZERO_WORD;
      sd_a <= 1'b0;
      sd_b <= 1'b0;
    end
    else if (tick)
    begin
      cnt <= wrap_a ? `DOPW_ZERO_WORD : cnt + 16'h0001;
      cnt_b <= wrap_b ? 8'h00 : cnt_b + 8'h01;
      acc_a <= sum_a[15:0];
      acc_b <= sum_b[15:0];
      sd_a <= sum_a[16];
      sd_b <= sum_b[16];
    end
  end

  // length of one modulator clock in reference cycles, for the return-to-zero half
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      since <= `DOPW_ZERO_WORD;
      span <= `DOPW_ZERO_WORD;
    end
    else if (tick)
    begin
      since <= `DOPW_ZERO_WORD;
      span <= since + 16'h0001;
    end
    else if (since != `DOPW_FULL_PERIOD)
      since <= since + 16'h0001;
  end

  // ************************************************
  // output waveform
  // ************************************************
  always_comb
  begin
    next_a = 1'b0;
    next_b = 1'b0;
    case (mode)
      dopw_pkg::DOPW_SINGLE:
      begin
        next_a = (cnt < act_a);
      end
      dopw_pkg::DOPW_TWIN8:
      begin
        next_a = (cnt < {8'h00, act_a[7:0]});
        next_b = (cnt[7:0] == act_b[15:8]) ? 1'b1 :
                 (cnt[7:0] == act_a[15:8]) ? 1'b0 : second_output_pin_o;
      end
      dopw_pkg::DOPW_TWIN16:
      begin
        next_a = (cnt < act_a);
        next_b = (cnt < act_b);
      end
      dopw_pkg::DOPW_SD_NRZ:
      begin
        next_a = sd_a;
        next_b = sd_b;
      end
      dopw_pkg::DOPW_DUAL8:
      begin
        next_a = (cnt < {8'h00, act_a[7:0]});
        next_b = (cnt_b < act_a[15:8]);
      end
      dopw_pkg::DOPW_SD_RZ:
      begin
        next_a = sd_a && rz_high;
        next_b = sd_b && rz_high;
      end
      default:
      begin
        next_a = 1'b0;
        next_b = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      first_output_pin_o <= 1'b0;
      second_output_pin_o <= 1'b0;
    end
    else
    begin
      first_output_pin_o <= next_a;
      second_output_pin_o <= next_b;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_ctrl_clears_cnt: assert property (wr_ctrl |=> cnt == `DOPW_ZERO_WORD)
    else $error("control write did not clear counter");
  chk_low_staged: assert property ((wr_a_lo && wide && !wr_a_hi) |=> word_a == $past(word_a))
    else $error("staged low byte leaked into word");
  chk_commit_waits: assert property ((wr_a_hi && !off && !cyc_end) |=> act_a == $past(act_a))
    else $error("committed word applied mid cycle");
  chk_commit_lands: assert property ((pend && cyc_end && !off)
    |=> act_a == $past(word_a))
    else $error("committed word not applied at cycle end");
  chk_mode_stored: assert property (wr_ctrl |=> mode == $past(sfr_wdata_i[6:4]))
    else $error("mode field not stored");
  chk_pins_released: assert property (off |-> !first_output_pin_oe_o && !second_output_pin_oe_o)
    else $error("pins driven while disabled");
  chk_single_wrap: assert property ((mode == dopw_pkg::DOPW_SINGLE && cyc_end)
    |=> cnt == `DOPW_ZERO_WORD)
    else $error("single mode counter missed its period");
  chk_twin16_fall: assert property ((mode == dopw_pkg::DOPW_TWIN16 && cnt == act_a
    && !wr_ctrl) |=> !first_output_pin_o)
    else $error("first output not low at equality");
  chk_twin16_sync: assert property ((mode == dopw_pkg::DOPW_TWIN16 &&
    cnt == `DOPW_ZERO_WORD && act_a != `DOPW_ZERO_WORD && act_b != `DOPW_ZERO_WORD &&
    !wr_ctrl) |=> first_output_pin_o && second_output_pin_o)
    else $error("outputs not high together after rollover");
  chk_twin8_fall: assert property ((mode == dopw_pkg::DOPW_TWIN8 &&
    cnt == {8'h00, act_a[7:0]} && !wr_ctrl) |=> !first_output_pin_o)
    else $error("twin 8-bit first output not low at match");
  chk_twin8_rise: assert property ((mode == dopw_pkg::DOPW_TWIN8 &&
    cnt[7:0] == act_b[15:8] && !wr_ctrl) |=> second_output_pin_o)
    else $error("twin 8-bit second output not set at match");

  cov_single_cycle: cover property (mode == dopw_pkg::DOPW_SINGLE && cyc_end);
  cov_commit_applied: cover property (pend && cyc_end && !off);
  cov_sd_high: cover property (mode == dopw_pkg::DOPW_SD_NRZ && sd_a && tick);
  cov_dual8_wrap: cover property (mode == dopw_pkg::DOPW_DUAL8 && tick && wrap_b);
endmodule : dopw_core

// ### rtl/dopw_defs.svh
// register map, field layout, codes and counts of the dual-output modulator
`ifndef DOPW_DEFS_SVH
`define DOPW_DEFS_SVH

`define DOPW_CNT_W 16
`define DOPW_ADDR_CTRL 8'hae
`define DOPW_ADDR_A_LO 8'hb1
`define DOPW_ADDR_A_HI 8'hb2
`define DOPW_ADDR_B_LO 8'hb3
`define DOPW_ADDR_B_HI 8'hb4
`define DOPW_CTRL_RESET 8'h00
`define DOPW_MODE_MSB 6
`define DOPW_MODE_LSB 4
`define DOPW_PRESC_MSB 3
`define DOPW_PRESC_LSB 2
`define DOPW_SRC_MSB 1
`define DOPW_SRC_LSB 0
`define DOPW_MODE_OFF 3'h0
`define DOPW_MODE_SINGLE 3'h1
`define DOPW_MODE_TWIN8 3'h2
`define DOPW_MODE_TWIN16 3'h3
`define DOPW_MODE_SD_NRZ 3'h4
`define DOPW_MODE_DUAL8 3'h5
`define DOPW_MODE_SD_RZ 3'h6
`define DOPW_MODE_RSVD 3'h7
`define DOPW_SRC_XTAL_DIV 2'h0
`define DOPW_SRC_XTAL 2'h1
`define DOPW_SRC_EXT 2'h2
`define DOPW_SRC_VCO 2'h3
`define DOPW_PRESC_LIM_1 6'h00
`define DOPW_PRESC_LIM_4 6'h03
`define DOPW_PRESC_LIM_16 6'h0f
`define DOPW_PRESC_LIM_64 6'h3f
`define DOPW_XTAL_DIV_LAST 4'he
`define DOPW_FULL_PERIOD 16'hffff
`define DOPW_ZERO_WORD 16'h0000

`endif

// ### rtl/dopw_pkg.sv
// types of the dual-output modulator
`include "dopw_defs.svh"
package dopw_pkg;
  typedef enum logic [2:0] {
    DOPW_OFF = `DOPW_MODE_OFF,
    DOPW_SINGLE = `DOPW_MODE_SINGLE,
    DOPW_TWIN8 = `DOPW_MODE_TWIN8,
    DOPW_TWIN16 = `DOPW_MODE_TWIN16,
    DOPW_SD_NRZ = `DOPW_MODE_SD_NRZ,
    DOPW_DUAL8 = `DOPW_MODE_DUAL8,
    DOPW_SD_RZ = `DOPW_MODE_SD_RZ,
    DOPW_RSVD = `DOPW_MODE_RSVD
  } dopw_mode_type;
endpackage : dopw_pkg

// ### rtl/dopw_tick_if.sv
// carrier between the modulator core and its clock generator
`timescale 1ns/1ns
interface dopw_tick_if;
  logic [1:0] src;
  logic [1:0] presc;
  logic clr;
  logic tick;
  modport core (output src, output presc, output clr, input tick);
  modport gen (input src, input presc, input clr, output tick);
endinterface : dopw_tick_if
